// ==== rtl/dpc_regs.sv ====
`timescale 1ns/1ps
// Operation
// - Offset 0x00 holds low sixteen word bits
// - Offset 0x01 bits 9:0 hold upper bits
// - Whole offset word resets to zero
// - Offset word is signed two's complement
// - Only high-word write applies new frequency
// - Enable bit ignored under pin control
// - Pull-up, pull-down, range fields at 0x05/0x06/0x02
// - Enable bit: zero disables, one enables
// - Unused upper bits read zero, ignore writes
// - Range selector picks one of sixteen
module dpc_regs (
    input  wire logic                         clock,
    input  wire logic                         rst,
    input  wire logic                         wr_en,
    input  wire logic [dpc_pkg::ADDR_W-1:0]   wr_addr,
    input  wire logic [dpc_pkg::REG_W-1:0]    wr_data,
    input  wire logic [dpc_pkg::ADDR_W-1:0]   rd_addr,
    output logic      [dpc_pkg::REG_W-1:0]    rd_data,
    input  wire logic                         oe_pin_mode,
    input  wire logic [dpc_pkg::SEL_W-1:0]    range_dflt,
    input  wire logic [dpc_pkg::SEL_W-1:0]    pullup_dflt,
    input  wire logic [dpc_pkg::SEL_W-1:0]    pulldn_dflt,
    output logic signed [dpc_pkg::FOW_W-1:0]  frequency_offset_word,
    output logic                              freq_update,
    output logic      [dpc_pkg::SEL_W-1:0]    pull_range_sel,
    output logic      [dpc_pkg::SEL_W-1:0]    pullup_strength,
    output logic      [dpc_pkg::SEL_W-1:0]    pulldn_strength,
    output logic                              sw_output_enable
);
    import dpc_pkg::*;

    logic [REG_W-1:0]  low_control_word_q;   // Staged low word
    logic [HIGH_W-1:0] high_control_word_q;  // Stored high bits
    logic              oe_q;                 // Software enable bit
    logic              wr_low;               // Strobe to low word
    logic              wr_high;              // Strobe to high word

    // Halves must join into the full word, enable bit above the high field
    if (HIGH_W + REG_W != FOW_W || OE_BIT < HIGH_W || OE_BIT >= REG_W) begin : g_geom_check
        $error("register geometry does not fit the word layout");
    end

    // Address decode of write strobes
    always_comb begin
        wr_low  = 1'b0;
        wr_high = 1'b0;
        if (wr_en && wr_addr == OFS_LOW) begin
            wr_low = 1'b1;
        end else if (wr_en && wr_addr == OFS_HIGH) begin
            wr_high = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            low_control_word_q <= RST_LOW;
        end else if (wr_low) begin
            low_control_word_q <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            high_control_word_q <= RST_HIGH;
        end else if (wr_high) begin
            high_control_word_q <= wr_data[HIGH_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            oe_q <= RST_OE;
        end else if (wr_high && !oe_pin_mode) begin
            oe_q <= wr_data[OE_BIT];
        end
    end

    assign sw_output_enable = oe_q;

    // signed word joined; zero at reset
    always_ff @(posedge clock) begin
        if (rst) begin
            frequency_offset_word <= '0;
            freq_update           <= 1'b0;
        end else begin
            freq_update <= wr_high;
            if (wr_high) begin
                // Fresh high bits joined with the staged low word
                frequency_offset_word <= {wr_data[HIGH_W-1:0], low_control_word_q};
            end
        end
    end

    dpc_field #(.W(SEL_W)) u_range (
        .clock   (clock),
        .rst     (rst),
        .wr_en   (wr_en && wr_addr == OFS_RANGE),
        .wr_data (wr_data[SEL_W-1:0]),
        .dflt    (range_dflt),
        .value_q (pull_range_sel)
    );
    dpc_field #(.W(SEL_W)) u_pullup (
        .clock   (clock),
        .rst     (rst),
        .wr_en   (wr_en && wr_addr == OFS_PULLUP),
        .wr_data (wr_data[SEL_W-1:0]),
        .dflt    (pullup_dflt),
        .value_q (pullup_strength)
    );
    dpc_field #(.W(SEL_W)) u_pulldn (
        .clock   (clock),
        .rst     (rst),
        .wr_en   (wr_en && wr_addr == OFS_PULLDN),
        .wr_data (wr_data[SEL_W-1:0]),
        .dflt    (pulldn_dflt),
        .value_q (pulldn_strength)
    );

    always_comb begin
        rd_data = '0;
        if (rd_addr == OFS_LOW) begin
            rd_data = low_control_word_q;
        end else if (rd_addr == OFS_HIGH) begin
            rd_data = {5'h00, oe_q, high_control_word_q};
        end else if (rd_addr == OFS_RANGE) begin
            rd_data = {12'h000, pull_range_sel};
        end else if (rd_addr == OFS_PULLUP) begin
            rd_data = {12'h000, pullup_strength};
        end else if (rd_addr == OFS_PULLDN) begin
            rd_data = {12'h000, pulldn_strength};
        end
    end

    // Low-word write alone never moves the applied word
    property p_low_holds;
        @(posedge clock) disable iff (rst) wr_low |=> $stable(frequency_offset_word);
    endproperty
    a_low_holds: assert property (p_low_holds) else $error("low write moved word");

    property p_apply;
        @(posedge clock) disable iff (rst)
            wr_high |=> freq_update && frequency_offset_word[FOW_W-1:REG_W] == $past(wr_data[HIGH_W-1:0]);
    endproperty
    a_apply: assert property (p_apply) else $error("high write not applied");

    property p_join_low;
        @(posedge clock) disable iff (rst)
            wr_high |=> frequency_offset_word[REG_W-1:0] == $past(low_control_word_q);
    endproperty
    a_join_low: assert property (p_join_low) else $error("low part not joined");

    property p_pin_oe;
        @(posedge clock) disable iff (rst) oe_pin_mode |=> $stable(sw_output_enable);
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("enable changed in pin mode");

    property p_sw_oe;
        @(posedge clock) disable iff (rst)
            wr_high && !oe_pin_mode |=> sw_output_enable == $past(wr_data[OE_BIT]);
    endproperty
    a_sw_oe: assert property (p_sw_oe) else $error("enable not written");

    property p_upper_zero;
        @(posedge clock) disable iff (rst)
            rd_addr == OFS_RANGE |-> rd_data[REG_W-1:SEL_W] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("unused bits nonzero");

    property p_reset_zero;
        @(posedge clock) $past(rst) |-> frequency_offset_word == '0 && !sw_output_enable;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

    property p_pullup;
        @(posedge clock) disable iff (rst)
            wr_en && wr_addr == OFS_PULLUP |=> pullup_strength == $past(wr_data[SEL_W-1:0]);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up not written");

    property p_no_update;
        @(posedge clock) disable iff (rst) !wr_high |=> !freq_update;
    endproperty
    a_no_update: assert property (p_no_update) else $error("spurious update");

    // Update steps: a lone high write, then exactly one pulse cycle
    sequence s_high_once;
        wr_high ##1 !wr_high;
    endsequence

    sequence s_pulse_once;
        freq_update ##1 !freq_update;
    endsequence

    // Host spacing keeps high writes apart, so each gives one short pulse
    property p_one_pulse;
        @(posedge clock) disable iff (rst) s_high_once |-> s_pulse_once;
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("update pulse not one cycle");

    // Applied word moves only on a high write
    property p_word_hold;
        @(posedge clock) disable iff (rst) !wr_high |=> $stable(frequency_offset_word);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("word moved without high write");

    // High readback keeps bits above the enable at zero
    property p_high_upper_zero;
        @(posedge clock) disable iff (rst)
            rd_addr == OFS_HIGH |-> rd_data[REG_W-1:OE_BIT+1] == '0;
    endproperty
    a_high_upper_zero: assert property (p_high_upper_zero) else $error("high upper bits nonzero");

    // Pull-down field takes the low nibble of its write
    property p_pulldn;
        @(posedge clock) disable iff (rst)
            wr_en && wr_addr == OFS_PULLDN |=> pulldn_strength == $past(wr_data[SEL_W-1:0]);
    endproperty
    a_pulldn: assert property (p_pulldn) else $error("pull-down not written");

    // Range code takes the low nibble of its write
    property p_range;
        @(posedge clock) disable iff (rst)
            wr_en && wr_addr == OFS_RANGE |=> pull_range_sel == $past(wr_data[SEL_W-1:0]);
    endproperty
    a_range: assert property (p_range) else $error("range not written");
endmodule

// ==== rtl/dpc_pkg.sv ====
package dpc_pkg;
    // Register word and field geometry
    localparam int unsigned REG_W        = 16;
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned FOW_W        = 26;
    localparam int unsigned HIGH_W       = 10;
    localparam int unsigned SEL_W        = 4;
    localparam int unsigned OE_BIT       = 10;
    // Register offsets
    localparam logic [7:0]  OFS_LOW      = 8'h00;
    localparam logic [7:0]  OFS_HIGH     = 8'h01;
    localparam logic [7:0]  OFS_RANGE    = 8'h02;
    localparam logic [7:0]  OFS_PULLUP   = 8'h05;
    localparam logic [7:0]  OFS_PULLDN   = 8'h06;
    // Values after reset
    localparam logic [15:0] RST_LOW      = 16'h0000;
    localparam logic [9:0]  RST_HIGH     = 10'h000;
    localparam logic        RST_OE       = 1'b0;
    // Host update spacing, for reference of the applied-word pulse
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned UPD_MAX_HZ   = 38_000;
    localparam int unsigned UPD_MIN_CYC  = CLK_HZ / UPD_MAX_HZ;
endpackage

// ==== rtl/dpc_field.sv ====
`timescale 1ns/1ps
// One narrow read-write field with a factory default captured at reset
module dpc_field #(
    parameter int unsigned W = 4
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    input  wire logic [W-1:0] dflt,
    output logic      [W-1:0] value_q
);
    // A zero-width field cannot hold any code
    if (W < 1) begin : g_width_check
        $error("field width must be at least one");
    end

    // Default comes from the factory strap, so it is loaded on a clocked reset
    always_ff @(posedge clock) begin
        if (rst) begin
            value_q <= dflt;
        end else if (wr_en) begin
            value_q <= wr_data;
        end
    end
endmodule

// ==== sim/dpc_host_model.sv ====
`timescale 1ns/1ps
// Host side model: one register write per wr call, two per word call
module dpc_host_model
    import dpc_pkg::*;
(
    input  wire logic         clock,
    output logic              wr_en,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [REG_W-1:0]  wr_data
);
    // Idle bus at time zero
    initial begin
        wr_en = 1'b0;
        wr_addr = 8'h00;
        wr_data = 16'h0000;
    end
    // One strobe cycle, then the bus shows junk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clock);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clock);
        wr_en = 1'b0;
        wr_addr = ~a;
        wr_data = ~d;
        if (a == OFS_HIGH) repeat (UPD_MIN_CYC) @(negedge clock);
    endtask
    task automatic word(input logic [25:0] w, input logic oe);
        wr(OFS_LOW, w[15:0]);
        wr(OFS_HIGH, {5'h00, oe, w[25:16]});
    endtask
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
// Register bank bench, host model as writer
module tb;
    import dpc_pkg::*;
    logic               clock = 1'b0;   // 40 MHz
    logic               rst = 1'b1;     // Sync reset
    logic               oe_pin_mode = 1'b0;
    logic [7:0]         rd_addr = 8'h00;
    logic [15:0]        rd_data;
    logic               wr_en, freq_update, sw_output_enable;
    logic [7:0]         wr_addr;
    logic [15:0]        wr_data;
    logic signed [25:0] frequency_offset_word;
    logic [3:0]         pull_range_sel, pullup_strength, pulldn_strength;
    int                 bad_count = 0, n_tests = 0, upd_n = 0, cyc = 0;
    always #12.5 clock = ~clock;
    dpc_host_model host_u (.clock(clock), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
    dpc_regs dut_u (.clock(clock), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(rd_addr), .rd_data(rd_data), .oe_pin_mode(oe_pin_mode), .range_dflt(4'ha),
        .pullup_dflt(4'h5), .pulldn_dflt(4'h3), .frequency_offset_word(frequency_offset_word),
        .freq_update(freq_update), .pull_range_sel(pull_range_sel),
        .pullup_strength(pullup_strength), .pulldn_strength(pulldn_strength),
        .sw_output_enable(sw_output_enable));
    // Pulse counter and hang guard; timeout far above the ~4.3k cycles used
    always @(posedge clock) begin
        cyc++;
        if (freq_update === 1'b1) upd_n++;
        if (cyc == 30000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        rd_addr = a;
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Values right after reset
    task automatic t_reset();
        `CHK(frequency_offset_word, 26'h0)
        `CHK(sw_output_enable, 1'b0)
        `CHK(pull_range_sel, 4'ha)
        `CHK({pullup_strength, pulldn_strength}, 8'h53)
        rd(OFS_HIGH);
        `CHK(rd_data, 16'h0000)
        $display("test reset done");
    endtask
    // Full word loads, positive then negative
    task automatic t_word();
        host_u.word(26'h0e66666, 1'b1);
        `CHK(frequency_offset_word, 26'sh0e66666)
        `CHK(upd_n, 1)
        `CHK(sw_output_enable, 1'b1)
        rd(OFS_LOW);
        `CHK(rd_data, 16'h6666)
        host_u.word(26'h3800000, 1'b1);
        `CHK(frequency_offset_word, -26'sd8388608)
        rd(OFS_HIGH);
        `CHK(rd_data, 16'h0780)
        $display("test word done");
    endtask
    // Low word alone leaves output untouched
    task automatic t_low_only();
        host_u.wr(OFS_LOW, 16'h1234);
        repeat (4) @(negedge clock);
        `CHK(frequency_offset_word, -26'sd8388608)
        `CHK(upd_n, 2)
        rd(OFS_LOW);
        `CHK(rd_data, 16'h1234)
        $display("test low only done");
    endtask
    // Software disable, then enable bit ignored under pin control, top bits dropped
    task automatic t_oe();
        host_u.wr(OFS_HIGH, 16'h0380);
        `CHK(sw_output_enable, 1'b0)
        `CHK(frequency_offset_word, 26'sh3801234)
        oe_pin_mode = 1'b1;
        host_u.wr(OFS_HIGH, 16'hfc01);
        `CHK(sw_output_enable, 1'b0)
        `CHK(frequency_offset_word, 26'sh0011234)
        `CHK(upd_n, 4)
        rd(OFS_HIGH);
        `CHK(rd_data, 16'h0001)
        $display("test oe done");
    endtask
    // Narrow fields and an unmapped place
    task automatic t_fields();
        host_u.wr(OFS_RANGE, 16'hfff7);
        host_u.wr(OFS_PULLUP, 16'h00fe);
        host_u.wr(OFS_PULLDN, 16'h8001);
        host_u.wr(8'h03, 16'hffff);
        `CHK(pull_range_sel, 4'h7)
        `CHK({pullup_strength, pulldn_strength}, 8'he1)
        rd(OFS_RANGE);
        `CHK(rd_data, 16'h0007)
        rd(OFS_PULLUP);
        `CHK(rd_data, 16'h000e)
        rd(OFS_PULLDN);
        `CHK(rd_data, 16'h0001)
        rd(8'h03);
        `CHK(rd_data, 16'h0000)
        $display("test fields done");
    endtask
    // Reset in mid-run restores defaults, first write after release lands
    task automatic t_rerst();
        @(negedge clock);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        `CHK(frequency_offset_word, 26'h0)
        `CHK(sw_output_enable, 1'b0)
        `CHK({pull_range_sel, pullup_strength, pulldn_strength}, 12'ha53)
        rd(OFS_LOW);
        `CHK(rd_data, 16'h0000)
        host_u.wr(OFS_PULLUP, 16'h0009);
        `CHK(pullup_strength, 4'h9)
        $display("test mid-run reset done");
    endtask
    // Main sequence
    initial begin
        repeat (5) @(negedge clock);
        rst = 1'b0;
        t_reset();
        t_word();
        t_low_only();
        t_oe();
        t_fields();
        t_rerst();
        print_verdict();
    end
endmodule
